//--- rtl/sfrp_pkg.sv
// constants and types for the serial flash read path
package sfrp_pkg;
    // ==========================================================
    // array geometry
    localparam int ADDR_W = 19;
    localparam int MEM_DEPTH = 524288;
    localparam logic [18:0] ADDR_TOP = 19'h7ffff;
    localparam logic [18:0] ADDR_LOW = 19'h00000;
    // ==========================================================
    // command codes
    localparam logic [7:0] OP_READ = 8'h03;
    localparam logic [7:0] OP_FAST = 8'h0b;
    // ==========================================================
    // rising-edge counts closing each phase
    localparam logic [5:0] BITS_OPC = 6'h08;
    localparam logic [5:0] BITS_ADDR = 6'h20;
    localparam logic [5:0] BITS_DUMMY = 6'h28;
    // ==========================================================
    // pin vector layout and filtered reset levels
    localparam int PIN_N = 3;
    localparam int PIN_CS = 2;
    localparam int PIN_SCK = 1;
    localparam int PIN_SI = 0;
    localparam logic [2:0] PIN_RST = 3'h4;
    // ==========================================================
    // buffer depth
    localparam logic [1:0] BUF_DEPTH = 2'h2;
    localparam logic [7:0] IDLE_BYTE = 8'hff;
    // ==========================================================
    // link decoder states
    typedef enum logic [2:0] {
        S_OPC,
        S_ADDR,
        S_DUMMY,
        S_ARMED,
        S_DATA,
        S_IGNORE
    } sfrp_state_e;
endpackage : sfrp_pkg

//--- rtl/sfrp_top.sv
// serial flash read path: pin sampling, decoder, array, buffer, shifter
`timescale 1ns/1ps
// ==========================================================
// Summary of operation
// - opcode 03h plus 24-bit address reads
// - first bit out after last address bit
// - opcode 0Bh adds eight ignored dummy bits
// - first bit out after last dummy bit
// - address advances per byte while clocked
// - address wraps from top to zero
// - chip select high ends the read
// - output floats while chip select high
module sfrp_top (
    input wire logic clk,
    input wire logic rstn,
    // link pins to and from the host
    input wire logic cs_n,
    input wire logic sck,
    input wire logic si,
    output logic so_out,
    output logic so_oe,
    // user side array load port
    input wire logic load_en,
    input wire logic [18:0] load_addr,
    input wire logic [7:0] load_data,
    // status
    output logic read_active
);

    // ==========================================================
    // pin synchronisers
    logic [2:0] pin_raw;
    logic [2:0] pin_s1;
    logic [2:0] pin_s2;
    logic [2:0] pin_s3;
    logic [2:0] pin_f;
    logic [2:0] pin_prev;

    assign pin_raw = {cs_n, sck, si};

    // three stages; a change counts once stages two and three agree
    genvar gi;
    generate
        for (gi = 0; gi < sfrp_pkg::PIN_N; gi++) begin : g_sync
            always_ff @(posedge clk or negedge rstn) begin
                if (!rstn) begin
                    pin_s1[gi] <= sfrp_pkg::PIN_RST[gi];
                    pin_s2[gi] <= sfrp_pkg::PIN_RST[gi];
                    pin_s3[gi] <= sfrp_pkg::PIN_RST[gi];
                    pin_f[gi] <= sfrp_pkg::PIN_RST[gi];
                    pin_prev[gi] <= sfrp_pkg::PIN_RST[gi];
                end else begin
                    pin_s1[gi] <= pin_raw[gi];
                    pin_s2[gi] <= pin_s1[gi];
                    pin_s3[gi] <= pin_s2[gi];
                    if (pin_s2[gi] == pin_s3[gi]) begin
                        pin_f[gi] <= pin_s3[gi];
                    end
                    pin_prev[gi] <= pin_f[gi];
                end
            end
        end
    endgenerate

    // ==========================================================
    // edge events on the filtered pins
    logic cs_act;
    logic cs_fall;
    logic sck_rise;
    logic sck_fall;
    logic si_bit;

    assign cs_act = ~pin_f[sfrp_pkg::PIN_CS];
    assign cs_fall = pin_prev[sfrp_pkg::PIN_CS] & ~pin_f[sfrp_pkg::PIN_CS];
    assign sck_rise = cs_act & ~pin_prev[sfrp_pkg::PIN_SCK]
        & pin_f[sfrp_pkg::PIN_SCK];
    assign sck_fall = cs_act & pin_prev[sfrp_pkg::PIN_SCK]
        & ~pin_f[sfrp_pkg::PIN_SCK];
    assign si_bit = pin_f[sfrp_pkg::PIN_SI];

    // ==========================================================
    // command decoder
    sfrp_pkg::sfrp_state_e state;
    sfrp_pkg::sfrp_state_e next_state;
    logic [5:0] bit_cnt;
    logic [5:0] next_cnt;
    logic [31:0] in_sh;
    logic [31:0] next_in;
    logic fast;
    logic arm;
    logic pop;

    assign next_cnt = bit_cnt + 6'h01;
    assign next_in = {in_sh[30:0], si_bit};

    // next phase on each rising clock and the first byte launch
    always_comb begin
        next_state = state;
        arm = 1'b0;
        case (state)
            sfrp_pkg::S_OPC: begin
                if (sck_rise && next_cnt == sfrp_pkg::BITS_OPC) begin
                    if (next_in[7:0] == sfrp_pkg::OP_READ) begin
                        next_state = sfrp_pkg::S_ADDR;
                    end else if (next_in[7:0] == sfrp_pkg::OP_FAST) begin
                        next_state = sfrp_pkg::S_ADDR;
                    end else begin
                        next_state = sfrp_pkg::S_IGNORE;
                    end
                end
            end
            sfrp_pkg::S_ADDR: begin
                if (sck_rise && next_cnt == sfrp_pkg::BITS_ADDR) begin
                    if (fast) begin
                        next_state = sfrp_pkg::S_DUMMY;
                    end else begin
                        next_state = sfrp_pkg::S_ARMED;
                        arm = 1'b1;
                    end
                end
            end
            sfrp_pkg::S_DUMMY: begin
                if (sck_rise && next_cnt == sfrp_pkg::BITS_DUMMY) begin
                    next_state = sfrp_pkg::S_ARMED;
                    arm = 1'b1;
                end
            end
            sfrp_pkg::S_ARMED: begin
                if (sck_fall) begin
                    next_state = sfrp_pkg::S_DATA;
                end
            end
            sfrp_pkg::S_DATA: next_state = sfrp_pkg::S_DATA;
            sfrp_pkg::S_IGNORE: next_state = sfrp_pkg::S_IGNORE;
            default: next_state = sfrp_pkg::S_IGNORE;
        endcase
    end

    // state register; chip select gates everything
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state <= sfrp_pkg::S_OPC;
        end else if (!cs_act || cs_fall) begin
            state <= sfrp_pkg::S_OPC;
        end else begin
            state <= next_state;
        end
    end

    // bit counter and input shifter, sampled on rising clock
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            bit_cnt <= 6'h00;
            in_sh <= 32'h0000_0000;
            fast <= 1'b0;
        end else if (!cs_act || cs_fall) begin
            bit_cnt <= 6'h00;
            fast <= 1'b0;
        end else if (sck_rise && (state == sfrp_pkg::S_OPC
                || state == sfrp_pkg::S_ADDR
                || state == sfrp_pkg::S_DUMMY)) begin
            bit_cnt <= next_cnt;
            in_sh <= next_in;
            if (state == sfrp_pkg::S_OPC
                    && next_cnt == sfrp_pkg::BITS_OPC) begin
                fast <= (next_in[7:0] == sfrp_pkg::OP_FAST);
            end
        end
    end

    // ==========================================================
    // flash array, loaded from the user side
    logic [7:0] mem [0:sfrp_pkg::MEM_DEPTH-1];
    logic [7:0] mem_q;
    logic [18:0] fetch_addr;
    logic rd_pend;
    logic issue;
    logic flush;
    logic [1:0] buf_cnt;
    logic [1:0] in_use;

    // a flush on deselect or arm drops stale prefetch
    assign flush = !cs_act || arm;
    assign in_use = buf_cnt + {1'b0, rd_pend};
    // back-pressure: no read issued unless a slot is free
    assign issue = !flush && (state == sfrp_pkg::S_ARMED
        || state == sfrp_pkg::S_DATA) && (in_use < sfrp_pkg::BUF_DEPTH);

    // array write and registered read
    always_ff @(posedge clk) begin
        if (load_en) begin
            mem[load_addr] <= load_data;
        end
        mem_q <= mem[fetch_addr];
    end

    // fetch address and read in flight
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            fetch_addr <= sfrp_pkg::ADDR_LOW;
            rd_pend <= 1'b0;
        end else if (flush) begin
            // fast read: the address sits above the eight dummy bits
            fetch_addr <= fast ? next_in[26:8] : next_in[18:0];
            rd_pend <= 1'b0;
        end else begin
            rd_pend <= issue;
            if (issue) begin
                if (fetch_addr == sfrp_pkg::ADDR_TOP) begin
                    fetch_addr <= sfrp_pkg::ADDR_LOW;
                end else begin
                    fetch_addr <= fetch_addr + 19'h00001;
                end
            end
        end
    end

    // ==========================================================
    // two-entry buffer between array and shifter
    logic [7:0] buf_mem [0:1];
    logic buf_wp;
    logic buf_rp;
    logic push_valid;
    logic push_ready;
    logic pop_valid;
    logic [7:0] pop_data;

    assign push_valid = rd_pend;
    assign push_ready = buf_cnt < sfrp_pkg::BUF_DEPTH;
    assign pop_valid = buf_cnt != 2'h0;
    assign pop_data = buf_mem[buf_rp];

    // storage; only written when a slot is free
    always_ff @(posedge clk) begin
        if (push_valid && push_ready) begin
            buf_mem[buf_wp] <= mem_q;
        end
    end

    // pointers and fill count
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            buf_wp <= 1'b0;
            buf_rp <= 1'b0;
            buf_cnt <= 2'h0;
        end else if (flush) begin
            buf_wp <= 1'b0;
            buf_rp <= 1'b0;
            buf_cnt <= 2'h0;
        end else begin
            if (push_valid && push_ready) begin
                buf_wp <= ~buf_wp;
            end
            if (pop && pop_valid) begin
                buf_rp <= ~buf_rp;
            end
            case ({push_valid && push_ready, pop && pop_valid})
                2'b10: buf_cnt <= buf_cnt + 2'h1;
                2'b01: buf_cnt <= buf_cnt - 2'h1;
                default: buf_cnt <= buf_cnt;
            endcase
        end
    end

    // ==========================================================
    // output shifter on falling clock
    logic [2:0] out_bit;
    logic [7:0] out_sh;

    // a byte is taken at the first falling edge of each byte slot
    assign pop = sck_fall && (state == sfrp_pkg::S_ARMED
        || (state == sfrp_pkg::S_DATA && out_bit == 3'h0));

    // serial output and its enable
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            so_out <= 1'b0;
            so_oe <= 1'b0;
            out_bit <= 3'h0;
            out_sh <= 8'h00;
        end else if (!cs_act) begin
            so_oe <= 1'b0;
            out_bit <= 3'h0;
        end else if (pop) begin
            // first bit of each byte
            // an empty buffer here would be an underrun; send idle ones
            so_oe <= 1'b1;
            out_bit <= 3'h1;
            so_out <= pop_valid ? pop_data[7] : 1'b1;
            out_sh <= pop_valid ? {pop_data[6:0], 1'b0}
                : sfrp_pkg::IDLE_BYTE;
        end else if (sck_fall && state == sfrp_pkg::S_DATA) begin
            out_bit <= out_bit + 3'h1;
            so_out <= out_sh[7];
            out_sh <= {out_sh[6:0], 1'b0};
        end
    end

    // status level for the user side
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            read_active <= 1'b0;
        end else begin
            read_active <= cs_act && (state == sfrp_pkg::S_ARMED
                || state == sfrp_pkg::S_DATA);
        end
    end

endmodule : sfrp_top

//--- sim/sfrp_top_properties.sv
// checker on the read path pins
`timescale 1ns/1ps
module sfrp_chk (
    input wire logic clk,
    input wire logic rstn,
    input wire logic cs_n,
    input wire logic sck,
    input wire logic so_out,
    input wire logic so_oe,
    input wire logic read_active
);
    // =====
    // clocks since the last raw sck fall, saturating
    logic sck_d;
    logic [3:0] age;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            sck_d <= 1'b0;
            age <= 4'hf;
        end else begin
            sck_d <= sck;
            if (sck_d && !sck) age <= 4'h0;
            else if (age != 4'hf) age <= age + 4'h1;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    // =====
    // pins need about four clocks to be seen
    property p_float; cs_n [*6] |-> !so_oe; endproperty
    property p_end; cs_n [*6] |-> !read_active; endproperty
    property p_sel; $rose(so_oe) |-> !$past(cs_n, 3); endproperty
    property p_act; $rose(so_oe) |-> read_active; endproperty
    property p_first; $rose(so_oe) |-> age <= 4'h7; endproperty
    property p_step;
        so_oe && $past(so_oe) && $changed(so_out) |-> age <= 4'h7;
    endproperty
    property p_drop; $fell(so_oe) |-> $past(cs_n, 3); endproperty
    property p_rst;
        disable iff (1'b0) !rstn |-> !so_oe && !so_out && !read_active;
    endproperty
    a_float: assert property (p_float) else $error("so driven");
    a_end: assert property (p_end) else $error("read stays");
    a_sel: assert property (p_sel) else $error("oe no cs");
    a_act: assert property (p_act) else $error("oe idle");
    a_first: assert property (p_first) else $error("late bit");
    a_step: assert property (p_step) else $error("bit moved");
    a_drop: assert property (p_drop) else $error("oe lost");
    a_rst: assert property (p_rst) else $error("reset out");
    c_rise: cover property ($rose(so_oe));
    c_fall: cover property ($fell(so_oe));
    c_bit: cover property (so_oe && $changed(so_out));
endmodule : sfrp_chk
bind sfrp_top sfrp_chk chk (.clk(clk), .rstn(rstn), .cs_n(cs_n),
    .sck(sck), .so_out(so_out), .so_oe(so_oe), .read_active(read_active));

//--- sim/sfrp_host.sv
// spi host model for the read path link
`timescale 1ns/1ps
module sfrp_host (
    output logic cs_n,
    output logic sck,
    output logic si,
    input wire logic so_out,
    input wire logic so_oe,
    output logic so_line
);
    int hp = 32;
    logic last = 1'b0;
    // released line shows the inverse of its last value
    always @(so_out or so_oe) begin
        if (so_oe) last = so_out;
        so_line = so_oe ? so_out : ~last;
    end
    // idle pins, clock parked low between frames
    initial begin
        cs_n = 1'b1;
        sck = 1'b0;
        si = 1'b0;
    end
    task frame(input logic [7:0] op, input logic [18:0] a,
               input int nb, input int n, output logic [7:0] d [8]);
        logic [39:0] v;
        v = {op, 5'h00, a, 8'ha5};
        cs_n = 1'b0;
        #hp;
        for (int i = 0; i < nb; i++) begin
            si = v[39 - i];
            #hp sck = 1'b1;
            #hp sck = 1'b0;
        end
        // sample on the rise, well after the device moved
        for (int k = 0; k < n; k++) begin
            for (int i = 0; i < 8; i++) begin
                #hp sck = 1'b1;
                d[k] = {d[k][6:0], so_line};
                #hp sck = 1'b0;
            end
        end
        #hp cs_n = 1'b1;
        si = ~si;
        #(4 * hp);
    endtask : frame
endmodule : sfrp_host

//--- sim/sfrp_top_tb.sv
// self-checking bench for the serial flash read path
`timescale 1ns/1ps
`define CHK(n, e, g) chk(n, e, g)
module sfrp_top_tb;
    logic clk, rstn, load_en, oe_seen;
    logic [18:0] load_addr;
    logic [7:0] load_data;
    logic [7:0] d [8];
    wire cs_n, sck, si, so_out, so_oe, so_line, read_active;
    int fail_count = 0;
    int checks_done = 0;
    sfrp_top uut (.clk(clk), .rstn(rstn), .cs_n(cs_n), .sck(sck),
        .si(si), .so_out(so_out), .so_oe(so_oe), .load_en(load_en),
        .load_addr(load_addr), .load_data(load_data),
        .read_active(read_active));
    sfrp_host host (.cs_n(cs_n), .sck(sck), .si(si), .so_out(so_out),
        .so_oe(so_oe), .so_line(so_line));
    // =====
    // clock and drive-enable watch
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    always @(posedge clk) if (so_oe) oe_seen <= 1'b1;
    // array contents derived from the address
    function automatic logic [7:0] pat(input logic [18:0] a);
        return a[7:0] ^ a[15:8] ^ {5'h00, a[18:16]} ^ 8'h3c;
    endfunction : pat
    task chk(input string n, input logic [7:0] e, input logic [7:0] g);
        checks_done++;
        if (g !== e) begin
            fail_count++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task give_verdict;
        $display("checks %0d errors %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : give_verdict
    // burst load, strobe held high across bytes
    task fill(input logic [18:0] a, input int n);
        for (int i = 0; i < n; i++) begin
            load_addr = a + 19'(i);
            load_data = pat(a + 19'(i));
            load_en = 1'b1;
            @(posedge clk);
            #1;
        end
        load_en = 1'b0;
    endtask : fill
    // one read frame, bytes and idle state compared
    task rd(input logic [7:0] op, input logic [18:0] a, input int n);
        host.frame(op, a, (op == sfrp_pkg::OP_FAST) ? 40 : 32, n, d);
        for (int k = 0; k < n; k++) begin
            `CHK("data", pat(a + 19'(k)), d[k]);
        end
        `CHK("so_oe", 8'h00, so_oe);
        `CHK("active", 8'h00, read_active);
    endtask : rd
    task t_std;
        rd(sfrp_pkg::OP_READ, 19'h00100, 4);
    endtask : t_std
    // dummy byte nonzero, so a shifted address shows up
    task t_fast;
        rd(sfrp_pkg::OP_FAST, 19'h00103, 3);
    endtask : t_fast
    task t_wrap;
        rd(sfrp_pkg::OP_READ, sfrp_pkg::ADDR_TOP - 19'h2, 5);
    endtask : t_wrap
    // unknown opcode, then an aborted address, then a clean read
    task t_restart;
        oe_seen = 1'b0;
        host.frame(8'h9f, 19'h00000, 32, 2, d);
        host.frame(sfrp_pkg::OP_READ, 19'h00100, 12, 0, d);
        `CHK("oe_seen", 8'h00, oe_seen);
        rd(sfrp_pkg::OP_READ, sfrp_pkg::ADDR_LOW, 2);
    endtask : t_restart
    // =====
    // main sequence
    initial begin
        rstn = 1'b0;
        load_en = 1'b0;
        load_addr = 19'h00000;
        load_data = 8'h00;
        oe_seen = 1'b0;
        repeat (2) @(posedge clk);
        #1 rstn = 1'b1;
        fill(sfrp_pkg::ADDR_LOW, 4);
        fill(19'h7fffc, 4);
        fill(19'h00100, 8);
        repeat (4) @(posedge clk);
        t_std();
        t_fast();
        t_wrap();
        t_restart();
        give_verdict();
    end
    // hang guard
    initial begin
        #200000;
        fail_count++;
        give_verdict();
    end
endmodule : sfrp_top_tb
